// File: logic/uetc_params.svh
`ifndef UETC_PARAMS_SVH
`define UETC_PARAMS_SVH

// Register byte offsets on the APB slave.
`define UETC_EP_OFS        8'h00
`define UETC_CTRL_OFS      8'h40
`define UETC_IRQ_STS_OFS   8'h44
`define UETC_IRQ_MASK_OFS  8'h48

// Endpoint register field positions.
`define UETC_EP_CRX        15
`define UETC_EP_RXTOG      14
`define UETC_EP_RXSTS_HI   13
`define UETC_EP_RXSTS_LO   12
`define UETC_EP_SETUP      11
`define UETC_EP_XTYPE_HI   10
`define UETC_EP_XTYPE_LO   9
`define UETC_EP_SPECIAL    8
`define UETC_EP_CTX        7
`define UETC_EP_TXTOG      6
`define UETC_EP_TXSTS_HI   5
`define UETC_EP_TXSTS_LO   4
`define UETC_EP_ADDR_HI    3
`define UETC_EP_ADDR_LO    0

// Control register fields, reset value and the bits it actually stores.
`define UETC_CTRL_IRQEN    15
`define UETC_CTRL_FORCE    0
`define UETC_CTRL_RST      16'h0003
`define UETC_CTRL_WMASK    16'h8003

// Interrupt status and mask bit positions.
`define UETC_IRQ_SEND      0
`define UETC_IRQ_RECV      1
`define UETC_IRQ_SETUP     2
`define UETC_IRQ_W         3

`endif

// File: logic/uetc_pkg.sv
package uetc_pkg;

  // Endpoint transfer type, in field encoding order 00 to 11.
  typedef enum logic [1:0] {
    UETC_BULK,
    UETC_CONTROL,
    UETC_ISO,
    UETC_INTR
  } uetc_endpoint_transfer_type_t;

  // Handshake status code, in field encoding order 00 to 11.
  typedef enum logic [1:0] {
    UETC_HS_DISABLED,
    UETC_HS_STALL,
    UETC_HS_NAK,
    UETC_HS_VALID
  } uetc_hs_t;

  // One-hot view of a handshake code: {valid, nak, stall, ignore}.
  typedef logic [3:0] uetc_hs_onehot_t;

endpackage

// File: logic/uetc_sync.sv
`timescale 1ns/1ps

// Two flip-flop synchroniser for a level arriving from outside the clock domain.
module uetc_sync
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);

  // First stage; only the second stage reads it.
  logic meta_reg;

  // Both stages clear under reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// File: logic/uetc_hs_decode.sv
`timescale 1ns/1ps

// Turns a two-bit handshake status code into a one-hot action vector.
module uetc_hs_decode
  import uetc_pkg::*;
(
  // Status code in.
  input  wire logic [1:0]      code,
  // Decoded actions out: {valid, nak, stall, ignore}.
  output uetc_hs_onehot_t      action
);

  // Each code lights exactly one action bit.
  assign action[0] = (code == UETC_HS_DISABLED);
  assign action[1] = (code == UETC_HS_STALL);
  assign action[2] = (code == UETC_HS_NAK);
  assign action[3] = (code == UETC_HS_VALID);

endmodule

// File: logic/uetc_top.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "uetc_params.svh"

module uetc_top
  import uetc_pkg::*;
(
  // Clock and synchronous active-low reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Events from the serial engine, same clock, one-cycle pulses.
  input  wire logic        in_done,
  input  wire logic        out_done,
  input  wire logic        setup_done,
  // Double-buffer fill level from the serial engine, same clock.
  input  wire logic        tx_buf_filled,
  // USB bus reset level from the line side, asynchronous.
  input  wire logic        bus_reset_async,
  // Endpoint controls toward the serial engine.
  output logic [3:0]       endpoint_number,
  output logic [1:0]       endpoint_transfer_type,
  output logic             double_buffer_select,
  output logic             status_out_select,
  output logic [3:0]       tx_action,
  output logic [3:0]       rx_action,
  output logic             tx_pid_data1,
  output logic             tx_buf_sel,
  output logic             rx_pid_data1,
  // Interrupt.
  output logic             irq
);

  // Synchronised bus reset level.
  logic bus_reset_s;

  // Endpoint register fields.
  logic [1:0]  endpoint_transfer_type_reg;            // Endpoint transfer type.
  logic        kind_reg;               // Endpoint special kind.
  logic [3:0]  addr_reg;               // Endpoint number.
  logic        ctx_reg;                // Correct send flag.
  logic        crx_reg;                // Correct receive flag.
  logic        txtog_reg;              // Transmit pid toggle.
  logic        rxtog_reg;              // Receive pid toggle.
  logic [1:0]  txsts_reg;              // Transmit handshake state.
  logic [1:0]  rxsts_reg;              // Receive handshake state.
  logic        setup_reg;              // Last receive was a SETUP.

  // Control, interrupt status and mask.
  logic [15:0] ctrl_reg;               // Control register storage.
  logic [2:0]  irq_sts_reg;            // Sticky event bits.
  logic [2:0]  irq_mask_reg;           // Interrupt mask bits.

  // Next values of the endpoint fields.
  logic        ctx_next;
  logic        crx_next;
  logic        txtog_next;
  logic        rxtog_next;
  logic [1:0]  txsts_next;
  logic [1:0]  rxsts_next;
  logic        setup_next;
  logic [2:0]  irq_sts_next;

  // Bus decode wires.
  logic        apb_setup;              // Setup phase of a transfer.
  logic        apb_wr;                 // Write taking effect this edge.
  logic        sel_ep;                 // Address hits the endpoint register.
  logic        sel_ctrl;               // Address hits the control register.
  logic        sel_sts;                // Address hits the interrupt status.
  logic        sel_mask;               // Address hits the interrupt mask.
  logic        sel_any;                // Address is mapped.
  logic        wr_ep;                  // Write to the endpoint register.
  logic [31:0] rd_data;                // Read data selected by address.
  logic [15:0] ep_view;                // Endpoint register as read.

  // Endpoint mode wires.
  logic        is_ctrl;                // Control endpoint.
  logic        is_iso;                 // Isochronous endpoint.
  logic        is_dbl;                 // Double-buffered bulk endpoint.
  logic        ep_reset;               // Endpoint register reset request.
  logic        rx_event;               // OUT or SETUP completed.
  logic        txtog_hw;               // Toggle after hardware events.
  logic        rxtog_hw;               // Receive toggle after hardware events.
  logic [1:0]  txsts_hw;               // Status after hardware events.
  logic [1:0]  rxsts_hw;               // Receive status after hardware events.
  logic [1:0]  tx_eff;                 // Transmit handshake the engine obeys.
  uetc_hs_onehot_t tx_dec;             // Decoded transmit action.
  uetc_hs_onehot_t rx_dec;             // Decoded receive action.

  // The bus reset comes from the line and must be synchronised first.
  uetc_sync u_bus_reset_sync
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (bus_reset_async),
    .sync_out (bus_reset_s)
  );

  // APB decode. The slave answers one cycle after setup, so the access
  // phase always ends at its first edge.
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign sel_ep    = (paddr == `UETC_EP_OFS);
  assign sel_ctrl  = (paddr == `UETC_CTRL_OFS);
  assign sel_sts   = (paddr == `UETC_IRQ_STS_OFS);
  assign sel_mask  = (paddr == `UETC_IRQ_MASK_OFS);
  assign sel_any   = sel_ep || sel_ctrl || sel_sts || sel_mask;
  assign wr_ep     = apb_wr && sel_ep;

  // Endpoint register image as software reads it.
  assign ep_view = {crx_reg, rxtog_reg, rxsts_reg, setup_reg, endpoint_transfer_type_reg,
                    kind_reg, ctx_reg, txtog_reg, txsts_reg, addr_reg};

  // Read data multiplexer; unused upper bits read as zero.
  assign rd_data = sel_ep   ? {16'h0000, ep_view} :
                   sel_ctrl ? {16'h0000, ctrl_reg} :
                   sel_sts  ? {29'h0000000, irq_sts_reg} :
                   sel_mask ? {29'h0000000, irq_mask_reg} :
                   32'h00000000;

  // Endpoint mode decode.
  // type and kind select mode
  assign is_ctrl  = (endpoint_transfer_type_reg == UETC_CONTROL);
  assign is_iso   = (endpoint_transfer_type_reg == UETC_ISO);
  assign is_dbl   = (endpoint_transfer_type_reg == UETC_BULK) && kind_reg;
  assign rx_event = out_done || setup_done;

  // Either a line reset or the force-reset control resets the endpoint.
  // reset sources combined
  assign ep_reset = bus_reset_s || ctrl_reg[`UETC_CTRL_FORCE];

  // Transmit toggle after hardware events. A SETUP forces DATA1 on a
  // control endpoint; otherwise each completed IN flips it, which is the
  // data toggle, the double-buffer flow control or the iso buffer swap.
  // SETUP sets toggle
  assign txtog_hw = (setup_done && is_ctrl) ? 1'b1 :
                    in_done                 ? !txtog_reg :
                    txtog_reg;

  // Software writing a one inverts the toggle; zero leaves it.
  // write one inverts
  assign txtog_next = txtog_hw ^ (wr_ep && pwdata[`UETC_EP_TXTOG]);

  // Transmit status: a good IN parks the endpoint at NAK, except on iso
  // and double-buffered endpoints where the status is left alone.
  // IN sets NAK
  assign txsts_hw = (in_done && !is_iso && !is_dbl) ? UETC_HS_NAK : txsts_reg;

  assign txsts_next = txsts_hw ^
                      (wr_ep ? pwdata[`UETC_EP_TXSTS_HI:`UETC_EP_TXSTS_LO] : 2'b00);

  // Receive toggle: SETUP clears it on control, otherwise each OUT or SETUP flips it.
  assign rxtog_hw   = (setup_done && is_ctrl) ? 1'b0 :
                      rx_event                ? !rxtog_reg :
                      rxtog_reg;
  assign rxtog_next = rxtog_hw ^ (wr_ep && pwdata[`UETC_EP_RXTOG]);

  // Receive status parks at NAK after a good OUT or SETUP, except on iso and double-buffered endpoints.
  assign rxsts_hw   = (rx_event && !is_iso && !is_dbl) ? UETC_HS_NAK : rxsts_reg;
  assign rxsts_next = rxsts_hw ^
                      (wr_ep ? pwdata[`UETC_EP_RXSTS_HI:`UETC_EP_RXSTS_LO] : 2'b00);

  // Correct send flag: a good IN sets it, a written zero clears it, and
  // the set wins when both land in one cycle.
  // IN sets flag
  assign ctx_next = in_done ? 1'b1 :
                    (wr_ep && !pwdata[`UETC_EP_CTX]) ? 1'b0 :
                    ctx_reg;

  // Correct receive flag behaves the same for OUT and SETUP.
  assign crx_next = rx_event ? 1'b1 :
                    (wr_ep && !pwdata[`UETC_EP_CRX]) ? 1'b0 :
                    crx_reg;

  // SETUP flag follows the kind of the last good receive.
  assign setup_next = setup_done ? 1'b1 :
                      out_done   ? 1'b0 :
                      setup_reg;

  // Sticky interrupt status: events set, written ones clear, set wins.
  assign irq_sts_next = (irq_sts_reg &
                         ~((apb_wr && sel_sts) ? pwdata[`UETC_IRQ_W-1:0] : 3'b000)) |
                        {setup_done, out_done, in_done};

  // Double-buffered bulk endpoints NAK while the engine has no filled
  // buffer, even when the status field says VALID.
  // buffer state governs
  assign tx_eff = (is_dbl && (txsts_reg == UETC_HS_VALID) && !tx_buf_filled) ?
                  UETC_HS_NAK : txsts_reg;

  // Decode of the transmit handshake actually used.
  // transmit decode
  uetc_hs_decode u_tx_decode
  (
    .code   (tx_eff),
    .action (tx_dec)
  );

  // Decode of the receive handshake.
  // receive decode
  uetc_hs_decode u_rx_decode
  (
    .code   (rxsts_reg),
    .action (rx_dec)
  );

  // APB answer: ready, error and read data registered at the setup edge.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !sel_any;
      prdata  <= apb_setup ? rd_data : 32'h00000000;
    end
  end

  // Control and mask registers; only the stored control bits are written.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg     <= `UETC_CTRL_RST;
      irq_mask_reg <= 3'b000;
    end
    else
    begin
      if (apb_wr && sel_ctrl)
      begin
        ctrl_reg <= pwdata[15:0] & `UETC_CTRL_WMASK;
      end
      if (apb_wr && sel_mask)
      begin
        irq_mask_reg <= pwdata[`UETC_IRQ_W-1:0];
      end
    end
  end

  // The two transfer flags survive a bus or forced reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctx_reg <= 1'b0;
      crx_reg <= 1'b0;
    end
    else
    begin
      ctx_reg <= ctx_next;
      crx_reg <= crx_next;
    end
  end

  // Remaining endpoint fields; held cleared during a bus or forced reset.
  // fields cleared
  always_ff @(posedge clk)
  begin
    if (!rst_n || ep_reset)
    begin
      endpoint_transfer_type_reg <= 2'b00;
      kind_reg    <= 1'b0;
      addr_reg    <= 4'h0;
      txtog_reg   <= 1'b0;
      rxtog_reg   <= 1'b0;
      txsts_reg   <= 2'b00;
      rxsts_reg   <= 2'b00;
      setup_reg   <= 1'b0;
    end
    else
    begin
      // Plain fields take the written value.
      if (wr_ep)
      begin
        endpoint_transfer_type_reg <= pwdata[`UETC_EP_XTYPE_HI:`UETC_EP_XTYPE_LO];
        kind_reg    <= pwdata[`UETC_EP_SPECIAL];
        addr_reg    <= pwdata[`UETC_EP_ADDR_HI:`UETC_EP_ADDR_LO];
      end
      txtog_reg <= txtog_next;
      rxtog_reg <= rxtog_next;
      txsts_reg <= txsts_next;
      rxsts_reg <= rxsts_next;
      setup_reg <= setup_next;
    end
  end

  // Sticky interrupt status bits.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_sts_reg <= 3'b000;
    end
    else
    begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  // Interrupt level: the enable in control gates all unmasked events.
  // enable gates irq
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= ctrl_reg[`UETC_CTRL_IRQEN] && |(irq_sts_reg & irq_mask_reg);
    end
  end

  // Registered controls toward the serial engine.
  // toggle picks PID
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      endpoint_number        <= 4'h0;
      endpoint_transfer_type <= 2'b00;
      double_buffer_select   <= 1'b0;
      status_out_select      <= 1'b0;
      tx_action              <= 4'h0;
      rx_action              <= 4'h0;
      tx_pid_data1           <= 1'b0;
      tx_buf_sel             <= 1'b0;
      rx_pid_data1           <= 1'b0;
    end
    else
    begin
      endpoint_number        <= addr_reg;
      endpoint_transfer_type <= endpoint_transfer_type_reg;
      double_buffer_select   <= is_dbl;
      status_out_select      <= is_ctrl && kind_reg;
      tx_action              <= tx_dec;
      rx_action              <= rx_dec;
      tx_pid_data1           <= txtog_reg;
      tx_buf_sel             <= txtog_reg;
      rx_pid_data1           <= rxtog_reg;
    end
  end

endmodule

// File: dv/uetc_engine_model.sv
`timescale 1ns/1ps

// Stand-in for the serial engine: event pulses, buffer level and bus reset.
module uetc_engine_model
(
  // Clock shared with the endpoint logic.
  input  wire logic clk,
  // Events and levels toward the endpoint logic.
  output logic      in_done,
  output logic      out_done,
  output logic      setup_done,
  output logic      tx_buf_filled,
  output logic      bus_reset_async
);
  // Everything is quiet at time zero.
  initial
  begin
    in_done = 1'b0;
    out_done = 1'b0;
    setup_done = 1'b0;
    tx_buf_filled = 1'b0;
    bus_reset_async = 1'b0;
  end

  // One event for exactly one clock: 0 is IN done, 1 OUT done, 2 SETUP done.
  task automatic pulse(input int kind);
    in_done <= (kind == 0);
    out_done <= (kind == 1);
    setup_done <= (kind == 2);
    @(posedge clk);
    in_done <= 1'b0;
    out_done <= 1'b0;
    setup_done <= 1'b0;
  endtask

  // Sets the level telling that the buffer to send holds data.
  task automatic fill(input logic v);
    tx_buf_filled <= v;
  endtask

  // Holds the bus reset level for a number of clocks.
  task automatic bus_reset(input int n);
    bus_reset_async <= 1'b1;
    repeat (n) @(posedge clk);
    bus_reset_async <= 1'b0;
  endtask
endmodule

// File: dv/uetc_properties.sv
`timescale 1ns/1ps

// Port-level checks on the endpoint logic.
module uetc_checker
(
  // Clock, reset and APB.
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Engine events and bus reset.
  input wire logic        in_done,
  input wire logic        out_done,
  input wire logic        setup_done,
  input wire logic        bus_reset_async,
  // Endpoint controls.
  input wire logic [1:0]  endpoint_transfer_type,
  input wire logic        double_buffer_select,
  input wire logic        status_out_select,
  input wire logic [3:0]  tx_action,
  input wire logic [3:0]  rx_action,
  input wire logic        tx_pid_data1
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // No register access and no bus reset in this cycle.
  sequence quiet_s;
    !(psel && penable) && !bus_reset_async;
  endsequence
  // Quiet, and no engine event either.
  sequence calm_s;
    !(psel && penable) && !bus_reset_async && !in_done && !out_done && !setup_done;
  endsequence
  // Endpoint out of reset with no reset or write arriving behind the event.
  sequence live_s;
    quiet_s ##0 (tx_action != 4'b0001) && !$past(psel && penable)
      && !$past(bus_reset_async) && !$past(bus_reset_async, 2);
  endsequence

  apb_answer_a: assert property (psel && !penable |=> pready
      && (pslverr == !(paddr inside {8'h00, 8'h40, 8'h44, 8'h48})))
    else $error("APB access not answered in one cycle with the right error");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready lasted more than one cycle");
  read_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside an answer");
  kind_select_a: assert property (
      (!double_buffer_select || endpoint_transfer_type == 2'b00)
      && (!status_out_select || endpoint_transfer_type == 2'b01))
    else $error("special kind output set for the wrong type");
  hs_onehot_a: assert property ($onehot0(tx_action) && $onehot0(rx_action))
    else $error("handshake action not one-hot");
  in_ack_nak_a: assert property (
      in_done && endpoint_transfer_type == 2'b01 ##0 live_s ##1 calm_s
      |=> tx_action == 4'b0100)
    else $error("completed IN did not leave the handshake at NAK");
  setup_toggle_a: assert property (
      setup_done && !in_done && endpoint_transfer_type == 2'b01 ##0 live_s ##1 calm_s
      |=> tx_pid_data1)
    else $error("SETUP on control endpoint did not set the toggle");
  iso_toggle_a: assert property (
      in_done && endpoint_transfer_type == 2'b10 ##0 live_s ##1 calm_s
      |=> tx_pid_data1 != $past(tx_pid_data1))
    else $error("isochronous packet did not invert the toggle");
  iso_keep_a: assert property (
      in_done && endpoint_transfer_type == 2'b10 ##0 live_s ##1 calm_s
      |=> $stable(tx_action))
    else $error("isochronous IN changed the handshake");
endmodule

bind uetc_top uetc_checker uetc_checker_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_done(in_done), .out_done(out_done), .setup_done(setup_done),
  .bus_reset_async(bus_reset_async), .endpoint_transfer_type(endpoint_transfer_type),
  .double_buffer_select(double_buffer_select), .status_out_select(status_out_select),
  .tx_action(tx_action), .rx_action(rx_action), .tx_pid_data1(tx_pid_data1));

// File: dv/usb_endpoint_tx_control_bench.sv
`timescale 1ns/1ps
`include "uetc_params.svh"

// Drives the endpoint logic over APB and through the engine model.
module usb_endpoint_tx_control_bench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        in_done, out_done, setup_done, tx_buf_filled, bus_reset_async, rd_err;
  logic [3:0]  endpoint_number, tx_action, rx_action;
  logic [1:0]  endpoint_transfer_type;
  logic        double_buffer_select, status_out_select, tx_pid_data1, tx_buf_sel, rx_pid_data1;
  int          err_count, tests_run, cur;

  // Design and its engine partner.
  uetc_top uetc_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_done(in_done), .out_done(out_done), .setup_done(setup_done),
    .tx_buf_filled(tx_buf_filled), .bus_reset_async(bus_reset_async),
    .endpoint_number(endpoint_number), .endpoint_transfer_type(endpoint_transfer_type),
    .double_buffer_select(double_buffer_select), .status_out_select(status_out_select),
    .tx_action(tx_action), .rx_action(rx_action), .tx_pid_data1(tx_pid_data1),
    .tx_buf_sel(tx_buf_sel), .rx_pid_data1(rx_pid_data1), .irq(irq));
  uetc_engine_model uetc_engine_model_inst (.clk(clk), .in_done(in_done),
    .out_done(out_done), .setup_done(setup_done), .tx_buf_filled(tx_buf_filled),
    .bus_reset_async(bus_reset_async));

  // 20 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One APB transfer; read data and error land in rd and rd_err.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16) err_count++;
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", exp, rd);
  endtask

  // Raises an engine event and lets the outputs follow.
  task automatic ev(input int kind);
    uetc_engine_model_inst.pulse(kind);
    repeat (2) @(posedge clk);
  endtask

  // Writes a register and waits for the lagging outputs.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hang short after 5000 clocks.
  initial
  begin
    #250000;
    err_count++;
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`UETC_EP_OFS, 32'h0);
    rdchk(`UETC_CTRL_OFS, 32'h3);
    apb(1'b0, 8'h80, 32'h0);
    chk("slverr", 32'h1, {31'h0, rd_err});
    wr(`UETC_CTRL_OFS, 32'h8000);
    wr(`UETC_IRQ_MASK_OFS, 32'h1);
    wr(`UETC_EP_OFS, 32'h82b5);
    rdchk(`UETC_EP_OFS, 32'h235);
    chk("number", 32'h5, {28'h0, endpoint_number});
    ev(0);
    chk("irq", 32'h1, {31'h0, irq});
    chk("tx_action", 32'h4, {28'h0, tx_action});
    chk("data1", 32'h1, {31'h0, tx_pid_data1});
    rdchk(`UETC_EP_OFS, 32'h2e5);
    rdchk(`UETC_IRQ_STS_OFS, 32'h1);
    wr(`UETC_IRQ_STS_OFS, 32'h1);
    rdchk(`UETC_IRQ_STS_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`UETC_IRQ_MASK_OFS, 32'h0);
    ev(0);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk(`UETC_IRQ_STS_OFS, 32'h1);
    wr(`UETC_CTRL_OFS, 32'h0);
    wr(`UETC_IRQ_MASK_OFS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`UETC_CTRL_OFS, 32'h8000);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk(`UETC_EP_OFS, 32'h2a5);
    wr(`UETC_EP_OFS, 32'h285);
    rdchk(`UETC_EP_OFS, 32'h2a5);
    wr(`UETC_EP_OFS, 32'h205);
    rdchk(`UETC_EP_OFS, 32'h225);
    wr(`UETC_EP_OFS, 32'h245);
    rdchk(`UETC_EP_OFS, 32'h265);
    wr(`UETC_EP_OFS, 32'h245);
    rdchk(`UETC_EP_OFS, 32'h225);
    cur = 2;
    for (int c = 0; c < 4; c++)
    begin
      wr(`UETC_EP_OFS, 32'h205 | ((cur ^ c) << 4));
      chk("tx_action", 32'h1 << c, {28'h0, tx_action});
      cur = c;
    end
    ev(2);
    chk("data1", 32'h1, {31'h0, tx_pid_data1});
    chk("rx_action", 32'h4, {28'h0, rx_action});
    chk("rx_data1", 32'h0, {31'h0, rx_pid_data1});
    wr(`UETC_EP_OFS, 32'h8485);
    ev(0);
    chk("data1", 32'h0, {31'h0, tx_pid_data1});
    chk("tx_action", 32'h8, {28'h0, tx_action});
    ev(0);
    chk("data1", 32'h1, {31'h0, tx_pid_data1});
    chk("buf_sel", 32'h1, {31'h0, tx_buf_sel});
    wr(`UETC_EP_OFS, 32'h8185);
    chk("double_buffer_select", 32'h1, {31'h0, double_buffer_select});
    chk("tx_action", 32'h4, {28'h0, tx_action});
    uetc_engine_model_inst.fill(1'b1);
    repeat (3) @(posedge clk);
    chk("tx_action", 32'h8, {28'h0, tx_action});
    wr(`UETC_EP_OFS, 32'h8385);
    chk("status_out", 32'h1, {31'h0, status_out_select});
    chk("double_buffer_select", 32'h0, {31'h0, double_buffer_select});
    ev(1);
    chk("rx_data1", 32'h1, {31'h0, rx_pid_data1});
    wr(`UETC_EP_OFS, 32'hb385);
    chk("rx_action", 32'h2, {28'h0, rx_action});
    uetc_engine_model_inst.bus_reset(4);
    repeat (4) @(posedge clk);
    apb(1'b0, `UETC_EP_OFS, 32'h0);
    chk("ep_cleared", 32'h0, rd & 32'h7f7f);
    chk("send_flag", 32'h80, rd & 32'h80);
    wr(`UETC_CTRL_OFS, 32'h8001);
    wr(`UETC_EP_OFS, 32'h235);
    apb(1'b0, `UETC_EP_OFS, 32'h0);
    chk("ep_forced", 32'h0, rd & 32'h7f7f);
    chk("tx_action", 32'h1, {28'h0, tx_action});
    wrap_up();
  end
endmodule
